// ---- hw/spi_port_pkg.sv ----
// Purpose: Shared constants for the serial peripheral port block
// Assumes: Byte-wide registers in the low bits of 32-bit Wishbone words
// Notes: Offsets are byte addresses on the register bus
`default_nettype none
package spi_port_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam logic [3:0] OFF_BREAK = 4'hC;
  // Control register fields
  localparam int CTL_RXIE = 7;
  localparam int CTL_MASTER = 5;
  localparam int CTL_CPOL = 4;
  localparam int CTL_CPHA = 3;
  localparam int CTL_WOM = 2;
  localparam int CTL_EN = 1;
  localparam int CTL_TXIE = 0;
  localparam logic [7:0] CTL_RESET = 8'h28;
  // Status/control register fields
  localparam int ST_RXF = 7;
  localparam int ST_ERROR_IRQ_ENABLE = 6;
  localparam int ST_OVR = 5;
  localparam int ST_MODE_FAULT_FLAG = 4;
  localparam int ST_TXE = 3;
  localparam int ST_MODE_FAULT_ENABLE = 2;
  localparam int ST_RATE_HI = 1;
  localparam int ST_RATE_LO = 0;
  localparam logic [7:0] ST_RESET = 8'h08;
  // Break control field
  localparam int BRK_BREAK_CLEAR_FLAG_ENABLE = 0;
  // Bits per byte
  localparam int BITS_PER_BYTE = 8;
endpackage
`default_nettype wire

// ---- hw/spi_rate_div.sv ----
// Purpose: Master bit-rate enable generator
// Assumes: One clock, enable pulses mark half serial-clock periods
// Notes: Divisor 2, 8, 32 or 128 gives half periods of 1, 4, 16, 64 cycles
`default_nettype none
module spi_rate_div (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic [1:0] rate_in,
  output logic half_out
);
  logic [5:0] cnt_r; // Half period counter
  logic [5:0] limit; // Terminal count for current rate

  // Decode rate code into half-period terminal count
  always_comb
  begin
    case (rate_in)
      2'b00: limit = 6'h00;
      2'b01: limit = 6'h03;
      2'b10: limit = 6'h0F;
      default: limit = 6'h3F;
    endcase
  end

  // Counter restarts when idle so first edge spacing is exact
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_r <= 6'h00;
      half_out <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_r <= 6'h00;
      half_out <= 1'b0;
    end
    else if (cnt_r >= limit)
    begin
      cnt_r <= 6'h00;
      half_out <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 6'h01;
      half_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hw/spi_shift_core.sv ----
// Purpose: Byte shift engine for master and slave
// Assumes: Pin inputs synchronous to the clock
// Notes: Slave edges detected by sampling the serial clock pin
`default_nettype none
module spi_shift_core (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic clear_in,
  input wire logic master_in,
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic half_in,
  input wire logic start_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic sdi_in,
  output logic sclk_out,
  output logic sdo_out,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rx_byte_out
);
  logic [7:0] sh_r; // Shift register
  logic [3:0] edges_r; // Clock edges seen in the byte
  logic sclk_d_r; // Last sampled slave clock
  logic edge_ev; // A serial clock edge this cycle
  logic lead; // Edge is leading (away from idle)
  logic samp; // Edge samples data
  logic slave_act; // Slave selected
  logic [7:0] in_r; // Received bits
  logic take_d_r; // Master sample due one cycle after its edge
  logic fin_r; // Master byte ends once its last sample is in
  logic take; // Shift a received bit this cycle

  assign slave_act = !master_in && !sel_n_in;
  assign lead = master_in ? (sclk_out == cpol_in) : (sclk_d_r == cpol_in);
  assign edge_ev = master_in ? (busy_out && !fin_r && half_in)
                             : (slave_act && (sclk_in != sclk_d_r));
  assign samp = (lead != cpha_in);
  // Clock pin lags by one flop; at fastest rate an early sample reads the old bit
  assign take = master_in ? take_d_r : (edge_ev && samp);

  // Shift, sample and count edges
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sh_r <= 8'h00;
      edges_r <= 4'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rx_byte_out <= 8'h00;
      sclk_out <= 1'b0;
      sdo_out <= 1'b0;
      sclk_d_r <= 1'b0;
      fin_r <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      sclk_d_r <= sclk_in;
      if (clear_in || (!master_in && sel_n_in && !cpha_in))
      begin
        // Disable or phase-0 slave deselect abandons the byte; select high ignores clocks
        edges_r <= 4'h0;
        busy_out <= 1'b0;
        sclk_out <= cpol_in;
        fin_r <= 1'b0;
      end
      else if (fin_r)
      begin
        // Last master sample lands now
        fin_r <= 1'b0;
        busy_out <= 1'b0;
        done_out <= 1'b1;
        rx_byte_out <= take ? {in_r[6:0], sdi_in} : in_r;
      end
      else if (start_in && !busy_out)
      begin
        sh_r <= tx_byte_in;
        edges_r <= 4'h0;
        busy_out <= 1'b1;
        if (!cpha_in)
          sdo_out <= tx_byte_in[7];
      end
      else if (edge_ev)
      begin
        if (master_in)
          sclk_out <= !sclk_out;
        if (samp)
          sh_r <= {sh_r[6:0], sdi_in};
        else if (cpha_in || edges_r != 4'h0)
          sdo_out <= sh_r[7];
        if (edges_r == 4'hF)
        begin
          edges_r <= 4'h0;
          if (master_in)
            fin_r <= 1'b1;
          else
          begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            rx_byte_out <= samp ? {in_r[6:0], sdi_in} : in_r;
          end
        end
        else
          edges_r <= edges_r + 4'h1;
      end
      else if (!master_in || !busy_out)
        sclk_out <= cpol_in; // R15
    end
  end

  // Received bits; master samples wait one cycle for the clock pin flop
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      in_r <= 8'h00;
      take_d_r <= 1'b0;
    end
    else
    begin
      take_d_r <= master_in && edge_ev && samp && !clear_in;
      if (take && !clear_in)
        in_r <= {in_r[6:0], sdi_in}; // R7
    end
  end
endmodule
`default_nettype wire

// ---- hw/spi_port.sv ----
// Purpose: SPI port pins, control and status registers
// Assumes: Classic Wishbone slave, pins synchronous to REF_CLK_IN
// Notes: Output enables high while the block drives a pin
//
// Overview of operation
// R1: Break with clear disabled freezes all flags
// R2: Break clears allowed when enabled, stay cleared
// R3: Armed first step survives break, then clears
// R4: Slave output driven only when selected slave
// R5: Enabled port owns data and clock directions
// R6: Master drives clock, slave receives; eight cycles
// R7: Master shifts out and in together
// R8: Master toggles select per byte when phase 0
// R9: Slave select always input for slaves
// R10: Deselected slave ignores serial clock edges
// R11: Select is general I/O unless fault-watching
// R12: Master watches select for mode fault
// R13: Receive enable gates receive-full request
// R14: Master bit chooses master or slave
// R15: Polarity sets idle level, phase timing
// R16: Wired-OR makes pins open-drain
// R17: Clearing enable stops and partially resets
// R18: Transmit-empty sets on load into shifter
// R19: Receive-full sets on byte arrival, two-step clear
// R20: Error enable gates overflow and mode fault
// R21: Overflow keeps old byte, drops new
// R22: Overflow clears by status then data read
// R23: Mode fault clears by status read, control write
// R24: Rate field divides clock by 2,8,32,128
// R25: First clear step recorded per flag
`default_nettype none
module spi_port (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic BREAK_IN,
  input wire logic SCLK_IN,
  output logic SCLK_OUT,
  output logic SCLK_OE_OUT,
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE_OUT,
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE_OUT,
  input wire logic SEL_N_IN,
  output logic SEL_PIN_OWNED_OUT,
  output logic TX_IRQ_OUT,
  output logic RX_ERR_IRQ_OUT
);
  logic [7:0] control_r; // Control register
  logic [7:0] status_r; // Status/control register (writable bits used)
  logic rxf_r; // Receive-full flag
  logic ovr_r; // Overrun flag
  logic mode_fault_flag_r; // Mode-fault flag
  logic txe_r; // Transmit-empty flag
  logic break_clear_flag_enable_r; // Break clear flag enable
  logic [7:0] rx_data_r; // Receive data register
  logic [7:0] tx_data_r; // Transmit holding register
  logic rxf_arm_r; // Status read saw receive-full
  logic ovr_arm_r; // Status read saw overrun
  logic mode_fault_flag_arm_r; // Status read saw mode fault
  logic en; // Port enabled
  logic master; // Master mode
  logic req; // Bus request present this cycle
  logic rd_stat; // Status read accepted
  logic rd_data; // Data read accepted
  logic wr_ctrl; // Control write accepted
  logic wr_data; // Data write accepted
  logic clr_ok; // Flag clear permitted
  logic fault_ev; // Mode fault condition
  logic half; // Master half-bit enable
  logic busy; // Byte in progress
  logic done; // Byte complete pulse
  logic [7:0] rx_byte; // Byte from the shifter
  logic sclk_drv; // Master serial clock
  logic sdo; // Serial data out
  logic sel_n_d_r; // Select one cycle ago
  logic slave_sel_seen_r; // Phase-0 slave selected since last byte
  logic load; // Move holding byte into shifter

  assign en = control_r[spi_port_pkg::CTL_EN];
  assign master = control_r[spi_port_pkg::CTL_MASTER]; // R14
  assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign rd_stat = req && !WB_WE_IN && WB_ADR_IN == spi_port_pkg::OFF_STATUS;
  assign rd_data = req && !WB_WE_IN && WB_ADR_IN == spi_port_pkg::OFF_DATA;
  assign wr_ctrl = req && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == spi_port_pkg::OFF_CONTROL;
  assign wr_data = req && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == spi_port_pkg::OFF_DATA;
  assign clr_ok = !BREAK_IN || break_clear_flag_enable_r; // R1 R2
  // Master fault: select low; slave fault: select high during a byte
  assign fault_ev = en && status_r[spi_port_pkg::ST_MODE_FAULT_ENABLE] &&
                    (master ? !SEL_N_IN : (SEL_N_IN && (busy || slave_sel_seen_r))); // R12 R9
  // Load only when the shifter is free; master starts, slave preloads
  assign load = en && !txe_r && !busy && !done &&
                (master || !SEL_N_IN || control_r[spi_port_pkg::CTL_CPHA]);

  // Baud generator for master mode only
  spi_rate_div u_div (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .run_in(en && master && busy),
    .rate_in(status_r[spi_port_pkg::ST_RATE_HI:spi_port_pkg::ST_RATE_LO]), // R24
    .half_out(half)
  );

  // Shift engine shared by both modes
  spi_shift_core u_core (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .clear_in(!en), // R17
    .master_in(master),
    .cpol_in(control_r[spi_port_pkg::CTL_CPOL]), // R15
    .cpha_in(control_r[spi_port_pkg::CTL_CPHA]),
    .half_in(half),
    .start_in(load),
    .tx_byte_in(tx_data_r),
    .sclk_in(SCLK_IN), // R6
    .sel_n_in(SEL_N_IN), // R10
    .sdi_in(master ? MISO_IN : MOSI_IN), // R7
    .sclk_out(sclk_drv),
    .sdo_out(sdo),
    .busy_out(busy),
    .done_out(done),
    .rx_byte_out(rx_byte)
  );

  // Wishbone acknowledge, one cycle after the request
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      WB_ACK_OUT <= 1'b0;
    else
      WB_ACK_OUT <= req;
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      WB_DAT_OUT <= 32'h0000_0000;
    else if (req && !WB_WE_IN)
    begin
      case (WB_ADR_IN)
        spi_port_pkg::OFF_CONTROL: WB_DAT_OUT <= {24'h00_0000, control_r};
        spi_port_pkg::OFF_STATUS: WB_DAT_OUT <= {24'h00_0000, rxf_r, status_r[6], ovr_r,
          mode_fault_flag_r, txe_r, status_r[2:0]};
        spi_port_pkg::OFF_DATA: WB_DAT_OUT <= {24'h00_0000, rx_data_r};
        spi_port_pkg::OFF_BREAK: WB_DAT_OUT <= {31'h0000_0000, break_clear_flag_enable_r};
        default: WB_DAT_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; master fault drops enable
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      control_r <= spi_port_pkg::CTL_RESET;
    else if (fault_ev && master)
      control_r[spi_port_pkg::CTL_EN] <= 1'b0; // R12
    else if (wr_ctrl)
      control_r <= WB_DAT_IN[7:0]; // R17
  end

  // Writable status bits and break control
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      status_r <= spi_port_pkg::ST_RESET;
      break_clear_flag_enable_r <= 1'b0;
    end
    else if (req && WB_WE_IN && WB_SEL_IN[0])
    begin
      if (WB_ADR_IN == spi_port_pkg::OFF_STATUS)
        status_r <= WB_DAT_IN[7:0] & 8'h47;
      if (WB_ADR_IN == spi_port_pkg::OFF_BREAK)
        break_clear_flag_enable_r <= WB_DAT_IN[spi_port_pkg::BRK_BREAK_CLEAR_FLAG_ENABLE];
    end
  end

  // Transmit holding register and empty flag
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      tx_data_r <= 8'h00;
      txe_r <= 1'b1;
    end
    else
    begin
      if (wr_data)
        tx_data_r <= WB_DAT_IN[7:0];
      // Set wins over the clearing write
      if (load || !en || (fault_ev && master))
        txe_r <= 1'b1; // R18 R17
      else if (wr_data && clr_ok)
        txe_r <= 1'b0; // R1
    end
  end

  // First clear step memory, kept through a protected break
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rxf_arm_r <= 1'b0;
      ovr_arm_r <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
    end
    else
    begin
      if (rd_stat && clr_ok)
      begin
        rxf_arm_r <= rxf_r; // R25
        ovr_arm_r <= ovr_r;
        mode_fault_flag_arm_r <= mode_fault_flag_r;
      end
      else if (rd_data && clr_ok)
      begin
        rxf_arm_r <= 1'b0; // R3
        ovr_arm_r <= 1'b0;
      end
      if (wr_ctrl && clr_ok)
        mode_fault_flag_arm_r <= 1'b0;
    end
  end

  // Receive register, receive-full and overrun
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rx_data_r <= 8'h00;
      rxf_r <= 1'b0;
      ovr_r <= 1'b0;
    end
    else
    begin
      if (done && rxf_r)
        ovr_r <= 1'b1; // R21
      else if (rd_data && clr_ok && ovr_arm_r)
        ovr_r <= 1'b0; // R22
      if (done && !rxf_r)
      begin
        rx_data_r <= rx_byte;
        rxf_r <= 1'b1; // R19
      end
      else if (rd_data && clr_ok && rxf_arm_r)
        rxf_r <= 1'b0; // R19 R3
    end
  end

  // Mode fault flag; fault present blocks the clear
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      mode_fault_flag_r <= 1'b0;
    else if (fault_ev)
      mode_fault_flag_r <= 1'b1;
    else if (wr_ctrl && clr_ok && mode_fault_flag_arm_r)
      mode_fault_flag_r <= 1'b0; // R23
  end

  // Phase-0 slave: selection itself opens a byte
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      sel_n_d_r <= 1'b1;
      slave_sel_seen_r <= 1'b0;
    end
    else
    begin
      sel_n_d_r <= SEL_N_IN;
      if (!en || master || control_r[spi_port_pkg::CTL_CPHA] || done)
        slave_sel_seen_r <= 1'b0;
      else if (sel_n_d_r && !SEL_N_IN)
        slave_sel_seen_r <= 1'b1; // R8
      else if (SEL_N_IN)
        slave_sel_seen_r <= 1'b0;
    end
  end

  // Pin drivers and enables
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      SCLK_OUT <= 1'b0;
      SCLK_OE_OUT <= 1'b0;
      MOSI_OUT <= 1'b0;
      MOSI_OE_OUT <= 1'b0;
      MISO_OUT <= 1'b0;
      MISO_OE_OUT <= 1'b0;
      SEL_PIN_OWNED_OUT <= 1'b0;
    end
    else
    begin
      // Open-drain: drive only lows, release for highs
      if (control_r[spi_port_pkg::CTL_WOM])
      begin
        SCLK_OUT <= 1'b0; // R16
        MOSI_OUT <= 1'b0;
        MISO_OUT <= 1'b0;
        SCLK_OE_OUT <= en && master && !sclk_drv;
        MOSI_OE_OUT <= en && master && !sdo;
        MISO_OE_OUT <= en && !master && !SEL_N_IN && !sdo;
      end
      else
      begin
        SCLK_OUT <= sclk_drv;
        MOSI_OUT <= sdo;
        MISO_OUT <= sdo;
        SCLK_OE_OUT <= en && master; // R5 R6
        MOSI_OE_OUT <= en && master; // R7
        MISO_OE_OUT <= en && !master && !SEL_N_IN; // R4
      end
      SEL_PIN_OWNED_OUT <= en && (!master || status_r[spi_port_pkg::ST_MODE_FAULT_ENABLE]); // R9 R11
    end
  end

  // Interrupt request lines
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      TX_IRQ_OUT <= 1'b0;
      RX_ERR_IRQ_OUT <= 1'b0;
    end
    else
    begin
      TX_IRQ_OUT <= txe_r && en && control_r[spi_port_pkg::CTL_TXIE]; // R18
      RX_ERR_IRQ_OUT <= (rxf_r && control_r[spi_port_pkg::CTL_RXIE]) || // R13
        ((ovr_r || mode_fault_flag_r) && status_r[spi_port_pkg::ST_ERROR_IRQ_ENABLE]); // R20
    end
  end
endmodule
`default_nettype wire

// ---- verif/spi_port_props.sv ----
// Purpose: Port-level checks for the SPI pin and register block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Sees only the top-level ports of the port block
`default_nettype none
module spi_port_props (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic SCLK_OE_OUT,
  input wire logic MOSI_OE_OUT,
  input wire logic MISO_OE_OUT,
  input wire logic SEL_N_IN,
  input wire logic SEL_PIN_OWNED_OUT,
  input wire logic TX_IRQ_OUT,
  input wire logic RX_ERR_IRQ_OUT
);
  // Single domain: one clocking and one reset for every check
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  logic req; // Request waiting for its answer
  assign req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  ack_prompt_a: assert property (req |=> WB_ACK_OUT)
    else $error("ack did not follow request");
  ack_once_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without request");
  dat_upper_a: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  // Offsets are word aligned, so low address bits mark an unmapped place
  unmapped_zero_a: assert property (req && !WB_WE_IN && WB_ADR_IN[1:0] != 2'h0
    |=> WB_DAT_OUT == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Allows up to two cycles of pin latency before the line must be released
  miso_desel_a: assert property (SEL_N_IN [*3] |-> !MISO_OE_OUT)
    else $error("slave output driven while deselected");
  sclk_miso_a: assert property (!(SCLK_OE_OUT && MISO_OE_OUT))
    else $error("clock and slave output driven together");
  mosi_miso_a: assert property (!(MOSI_OE_OUT && MISO_OE_OUT))
    else $error("both data lines driven together");
  sel_owned_a: assert property (MISO_OE_OUT |-> SEL_PIN_OWNED_OUT)
    else $error("selected slave does not own select pin");
  // Main scenarios reached
  cover property (MISO_OE_OUT);
  cover property ($rose(RX_ERR_IRQ_OUT));
  cover property ($rose(TX_IRQ_OUT));
endmodule
`default_nettype wire

// ---- verif/spi_peer_model.sv ----
// Purpose: Behavioural far-end SPI slave for the port bench
// Assumes: Select made by the bench, clock by the port under test
// Notes: Reloads its reply byte after every eight bits
`default_nettype none
module spi_peer_model (
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic mosi_in,
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic [7:0] tx_in,
  output logic miso_out,
  output logic [7:0] rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00; // Shift register
  int n = 0; // Bits taken this byte
  initial miso_out = 1'b0;
  initial rx_out = 8'h00;
  // Phase 0 shows the first bit on select, before any clock edge
  always @(negedge sel_n_in)
  begin
    sh = tx_in;
    n = 0;
    miso_out = tx_in[7];
  end
  // Released line shows the inverse, never a stale bit
  always @(posedge sel_n_in) miso_out = ~miso_out;
  // Leading edge samples for phase 0, trailing edge for phase 1
  always @(sclk_in)
  begin
    if (!sel_n_in && ((sclk_in != cpol_in) != cpha_in))
    begin
      sh = {sh[6:0], mosi_in};
      n++;
      if (n == 8)
      begin
        rx_out = sh;
        sh = tx_in;
        n = 0;
      end
    end
    else if (!sel_n_in)
      miso_out = sh[7];
  end
endmodule
`default_nettype wire

// ---- verif/spi_port_test.sv ----
// Purpose: Self-checking bench for the SPI pin and register block
// Assumes: Far side is the behavioural peer slave, lines pulled up
// Notes: Registers reached over classic Wishbone single cycles
`default_nettype none
module spi_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, brk = 0, sel_n = 1, psel_n = 1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, dat_o, rdat;
  logic ack, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, owned, tx_irq, rx_irq;
  logic sclk_w, mosi_w, miso_w, peer_miso, cpol = 0, cpha = 0;
  logic [7:0] peer_tx = 8'h00, peer_rx, a, b, c;
  int miscompares = 0, comparisons = 0, cycles = 0, edges = 0, period = 0;
  time last = 0;
  always #5 clk = ~clk;
  // Released clock and MOSI lines float high through pull-ups; released MISO follows the peer
  assign sclk_w = sclk_oe ? sclk_o : 1'b1;
  assign mosi_w = mosi_oe ? mosi_o : 1'b1;
  assign miso_w = miso_oe ? miso_o : peer_miso;
  spi_port u_spi_port (.REF_CLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_o),
    .WB_ACK_OUT(ack), .BREAK_IN(brk), .SCLK_IN(sclk_w), .SCLK_OUT(sclk_o),
    .SCLK_OE_OUT(sclk_oe), .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_oe),
    .MISO_IN(miso_w), .MISO_OUT(miso_o), .MISO_OE_OUT(miso_oe), .SEL_N_IN(sel_n),
    .SEL_PIN_OWNED_OUT(owned), .TX_IRQ_OUT(tx_irq), .RX_ERR_IRQ_OUT(rx_irq));
  spi_peer_model u_spi_peer_model (.sclk_in(sclk_w), .sel_n_in(psel_n), .mosi_in(mosi_w),
    .cpol_in(cpol), .cpha_in(cpha), .tx_in(peer_tx), .miso_out(peer_miso), .rx_out(peer_rx));
  // Serial clock rising edges and the spacing of the first two
  always @(posedge sclk_w)
  begin
    if (edges == 1)
      period = int'($time - last);
    last = $time;
    edges++;
  end
  // Hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; waits for ack, then releases
  task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] d);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= {24'h00_0000, d};
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (ack !== 1'b1 && t < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask
  // One master byte; polls status until bit bt rises
  task automatic xfer(input logic [7:0] d, input logic [7:0] p, input int bt);
    int t;
    peer_tx = p;
    psel_n <= 1'b0;
    edges = 0;
    wb(1'b1, spi_port_pkg::OFF_DATA, d);
    t = 0;
    rdat = 32'h0000_0000;
    while (rdat[bt] !== 1'b1 && t < 600)
    begin
      wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
      t++;
    end
    if (rdat[bt] !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    check(edges, 8);
    check(sclk_w, cpol);
    check(rdat[3], 1);
    check(peer_rx, d);
    psel_n <= 1'b1;
    @(posedge clk);
  endtask
  initial
  begin
    void'($urandom(28));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, spi_port_pkg::OFF_CONTROL, 8'h00);
    check(rdat, spi_port_pkg::CTL_RESET);
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(rdat, spi_port_pkg::ST_RESET);
    wb(1'b1, 4'h2, 8'hFF);
    wb(1'b0, 4'h2, 8'h00);
    check(rdat, 0);
    // Every rate code, each with a different clock mode
    for (int i = 0; i < 4; i++)
    begin
      cpol = i[1];
      cpha = i[0];
      wb(1'b1, spi_port_pkg::OFF_STATUS, 8'(i));
      wb(1'b1, spi_port_pkg::OFF_CONTROL, 8'(8'h22 | (i << 3)));
      wb(1'b0, spi_port_pkg::OFF_CONTROL, 8'h00);
      check(rdat, 8'h22 | (i << 3));
      a = $urandom;
      b = $urandom;
      xfer(a, b, 7);
      check(period, 20 << (2 * i));
      wb(1'b0, spi_port_pkg::OFF_DATA, 8'h00);
      check(rdat, b);
      wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
      check(rdat, i | 8'h08);
    end
    // Second byte before the first is read
    wb(1'b1, spi_port_pkg::OFF_STATUS, 8'h40);
    xfer(a, b, 7);
    c = $urandom;
    xfer(c, c ^ 8'hA5, 5);
    check(rx_irq, 1);
    wb(1'b0, spi_port_pkg::OFF_DATA, 8'h00);
    check(rdat, b);
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(rdat, 8'h48);
    // Break with clearing disabled, first step taken before
    xfer(a, b, 7);
    brk <= 1'b1;
    wb(1'b0, spi_port_pkg::OFF_DATA, 8'h00);
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(rdat, 8'hC8);
    brk <= 1'b0;
    wb(1'b0, spi_port_pkg::OFF_DATA, 8'h00);
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(rdat, 8'h48);
    // Break with clearing enabled
    wb(1'b1, spi_port_pkg::OFF_BREAK, 8'h01);
    xfer(a, b, 7);
    brk <= 1'b1;
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    wb(1'b0, spi_port_pkg::OFF_DATA, 8'h00);
    brk <= 1'b0;
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(rdat, 8'h48);
    // Master fault from the select pin
    wb(1'b1, spi_port_pkg::OFF_STATUS, 8'h44);
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(owned, 1);
    sel_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(rx_irq, 1);
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(rdat, 8'h5C);
    wb(1'b0, spi_port_pkg::OFF_CONTROL, 8'h00);
    check(rdat, 8'h38);
    sel_n <= 1'b1;
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    wb(1'b1, spi_port_pkg::OFF_CONTROL, 8'h20);
    wb(1'b0, spi_port_pkg::OFF_STATUS, 8'h00);
    check(rdat, 8'h4C);
    check(owned, 0);
    // Interrupt gating
    cpol = 1'b0;
    cpha = 1'b0;
    wb(1'b1, spi_port_pkg::OFF_STATUS, 8'h00);
    wb(1'b1, spi_port_pkg::OFF_CONTROL, 8'h27);
    wb(1'b0, spi_port_pkg::OFF_CONTROL, 8'h00);
    check(tx_irq, 1);
    check({sclk_oe, sclk_o, mosi_o}, 3'b100);
    wb(1'b1, spi_port_pkg::OFF_CONTROL, 8'hA6);
    xfer(c, a, 7);
    check(rx_irq, 1);
    wb(1'b0, spi_port_pkg::OFF_DATA, 8'h00);
    check(rdat, a);
    wb(1'b0, spi_port_pkg::OFF_CONTROL, 8'h00);
    check(rx_irq, 0);
    // Enabled slave, selected then deselected
    wb(1'b1, spi_port_pkg::OFF_CONTROL, 8'h02);
    sel_n <= 1'b0;
    repeat (3) @(posedge clk);
    check({miso_oe, sclk_oe, owned}, 3'b101);
    sel_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(miso_oe, 0);
    stop_test();
  end
endmodule
bind spi_port spi_port_props u_spi_port_props (.*);
`default_nettype wire
